// ---- sss_exec.sv ----
// Execution unit for subtract, nibble swap and conditional skips
`timescale 1ns/1ps
module sss_exec
    import sss_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic exec_valid_i,
    input wire sss_instr_t instr_i,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    output logic mem_we_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    output logic [DATA_W-1:0] working_register_o,
    output sss_flags_t flags_o,
    output logic skip_o,
    output logic dummy_cycle_o,
    output logic busy_o
);
    //--------------------------------------------------------------
    // Sequencer state
    //--------------------------------------------------------------
    typedef enum logic {
        SSS_ST_RUN = 1'b0,
        SSS_ST_DUMMY = 1'b1
    } sss_state_t;

    sss_state_t state;
    sss_state_t next_state;
    logic [DATA_W-1:0] working_register;
    logic [DATA_W-1:0] sub_rhs;
    logic [DATA_W-1:0] diff;
    logic [DATA_W-1:0] swapped;
    sss_flags_t sub_flags;
    logic take;
    logic skip_cond;

    //--------------------------------------------------------------
    // Datapath
    //--------------------------------------------------------------
    assign sub_rhs = (instr_i.op == SSS_OP_SUB_IMM) ? instr_i.imm
                                                    : mem_rdata_i;

    sss_subtractor u_sub (
        .minuend_i(working_register),
        .subtrahend_i(sub_rhs),
        .diff_o(diff),
        .flags_o(sub_flags)
    );

    assign swapped = {mem_rdata_i[NIB_W-1:0],
                      mem_rdata_i[DATA_W-1:NIB_W]};

    // Requests during the dummy cycle are ignored by design
    assign take = exec_valid_i && (state == SSS_ST_RUN);

    always_comb begin
        unique case (instr_i.op)
            SSS_OP_SKIP_NIL,
            SSS_OP_SKIP_NIL_LOAD:
                skip_cond = (mem_rdata_i == ZERO_BYTE);
            SSS_OP_SKIP_BIT_CLR:
                skip_cond = ~mem_rdata_i[instr_i.bit_idx];
            default:
                skip_cond = 1'b0;
        endcase
    end

    always_comb begin
        next_state = SSS_ST_RUN;
        if (take && skip_cond) begin
            next_state = SSS_ST_DUMMY;
        end
    end

    //--------------------------------------------------------------
    // Sequencing
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state <= SSS_ST_RUN;
            skip_o <= 1'b0;
            dummy_cycle_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            state <= next_state;
            // Not taken: skip stays low, next instruction runs
            skip_o <= take && skip_cond;
            dummy_cycle_o <= (next_state == SSS_ST_DUMMY);
            busy_o <= (next_state == SSS_ST_DUMMY);
        end
    end

    //--------------------------------------------------------------
    // Working register and flags
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            working_register <= WR_RESET;
        end else if (take) begin
            unique case (instr_i.op)
                SSS_OP_SUB_IMM:
                    working_register <= diff;
                SSS_OP_SWAP_WR:
                    working_register <= swapped;
                SSS_OP_SKIP_NIL_LOAD:
                    working_register <= mem_rdata_i;
                default:
                    working_register <= working_register;
            endcase
        end
    end

    assign working_register_o = working_register;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            flags_o <= FLAGS_RESET;
        end else if (take && (instr_i.op == SSS_OP_SUB_MEM
                           || instr_i.op == SSS_OP_SUB_IMM)) begin
            flags_o <= sub_flags;
        end
    end

    //--------------------------------------------------------------
    // Memory write-back
    //--------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mem_we_o <= 1'b0;
            mem_wdata_o <= ZERO_BYTE;
        end else begin
            mem_we_o <= take && (instr_i.op == SSS_OP_SUB_MEM
                              || instr_i.op == SSS_OP_SWAP_MEM);
            if (take && instr_i.op == SSS_OP_SUB_MEM) begin
                mem_wdata_o <= diff;
            end else if (take && instr_i.op == SSS_OP_SWAP_MEM) begin
                mem_wdata_o <= swapped;
            end
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    a_skip_dummy_pair:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        skip_o |-> dummy_cycle_o ##1 !dummy_cycle_o)
        else $error("dummy cycle not exactly one after skip");

    a_carry_borrow:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take && instr_i.op == SSS_OP_SUB_IMM
        |=> flags_o.carry == ($past(working_register) >= $past(instr_i.imm)))
        else $error("carry does not reflect borrow");

    a_sub_imm_wr:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take && instr_i.op == SSS_OP_SUB_IMM
        |=> working_register
            == 8'($past(working_register) - $past(instr_i.imm)))
        else $error("immediate subtract result wrong");

    a_sub_mem_wr:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take && instr_i.op == SSS_OP_SUB_MEM
        |=> mem_we_o && mem_wdata_o
            == 8'($past(working_register) - $past(mem_rdata_i)))
        else $error("memory subtract write wrong");

    a_swap_mem:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take && instr_i.op == SSS_OP_SWAP_MEM
        |=> mem_we_o && $stable(flags_o)
            && mem_wdata_o[NIB_W-1:0]
               == $past(mem_rdata_i[DATA_W-1:NIB_W])
            && mem_wdata_o[DATA_W-1:NIB_W]
               == $past(mem_rdata_i[NIB_W-1:0]))
        else $error("nibble swap to memory wrong");

    a_swap_wr_only:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take && instr_i.op == SSS_OP_SWAP_WR
        |=> !mem_we_o && $stable(flags_o)
            && working_register[DATA_W-1:NIB_W]
               == $past(mem_rdata_i[NIB_W-1:0])
            && working_register[NIB_W-1:0]
               == $past(mem_rdata_i[DATA_W-1:NIB_W]))
        else $error("swap to working register wrong");

    a_skip_nil:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take && instr_i.op == SSS_OP_SKIP_NIL
        |=> skip_o == ($past(mem_rdata_i) == ZERO_BYTE) && !mem_we_o
            && $stable(working_register))
        else $error("skip on zero wrong");

    a_skip_load:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take && instr_i.op == SSS_OP_SKIP_NIL_LOAD
        |=> working_register == $past(mem_rdata_i)
            && skip_o == (working_register == ZERO_BYTE))
        else $error("skip with load wrong");

    a_skip_bit:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take && instr_i.op == SSS_OP_SKIP_BIT_CLR
        |=> skip_o == !$past(mem_rdata_i[instr_i.bit_idx]))
        else $error("skip on clear bit wrong");

    a_no_skip_run:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !skip_o |-> !dummy_cycle_o)
        else $error("dummy cycle without skip");

    // A failed zero test must leave the next request free to be taken
    a_no_skip_next:
    assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        take && instr_i.op == SSS_OP_SKIP_NIL && mem_rdata_i != ZERO_BYTE
        |=> !skip_o && !busy_o)
        else $error("skip taken on a nonzero byte");
endmodule

// ---- sss_mem_model.sv ----
// Data memory model standing at the far side of the execution block
`timescale 1ns/1ps
module sss_mem_model
    import sss_pkg::*;
(
    input wire logic clk_i,
    input wire logic [1:0] addr_i,
    input wire logic we_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o
);
    // Plain always: the bench preloads bytes through the hierarchy
    logic [DATA_W-1:0] mem [4];
    logic [1:0] addr_q;

    assign rdata_o = mem[addr_i];

    // The write lands one cycle after the request, so the address is held
    always @(posedge clk_i) begin
        addr_q <= addr_i;
        if (we_i) begin
            mem[addr_q] <= wdata_i;
        end
    end
endmodule

// ---- sss_pkg.sv ----
// Package for the subtract, swap and skip execution block
package sss_pkg;

    localparam int DATA_W = 8;
    localparam int BIT_IDX_W = 3;
    localparam int NIB_W = 4;

    // Operation codes presented by the sequencer
    typedef enum logic [2:0] {
        SSS_OP_NONE = 3'b000,
        SSS_OP_SUB_MEM = 3'b001,
        SSS_OP_SUB_IMM = 3'b010,
        SSS_OP_SWAP_MEM = 3'b011,
        SSS_OP_SWAP_WR = 3'b100,
        SSS_OP_SKIP_NIL = 3'b101,
        SSS_OP_SKIP_NIL_LOAD = 3'b110,
        SSS_OP_SKIP_BIT_CLR = 3'b111
    } sss_op_t;

    typedef struct packed {
        sss_op_t op;
        logic [DATA_W-1:0] imm;
        logic [BIT_IDX_W-1:0] bit_idx;
    } sss_instr_t;

    typedef struct packed {
        logic twos_complement_range_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } sss_flags_t;

    localparam logic [DATA_W-1:0] WR_RESET = 8'h00;
    localparam sss_flags_t FLAGS_RESET = '0;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

endpackage

// ---- sss_subtractor.sv ----
// Eight-bit subtractor with borrow-style carry and flag outputs
`timescale 1ns/1ps
module sss_subtractor
    import sss_pkg::*;
(
    input wire logic [DATA_W-1:0] minuend_i,
    input wire logic [DATA_W-1:0] subtrahend_i,
    output logic [DATA_W-1:0] diff_o,
    output sss_flags_t flags_o
);
    logic [DATA_W:0] full;
    logic [NIB_W:0] low;

    always_comb begin
        full = {1'b0, minuend_i} - {1'b0, subtrahend_i};
        low = {1'b0, minuend_i[NIB_W-1:0]}
            - {1'b0, subtrahend_i[NIB_W-1:0]};
        diff_o = full[DATA_W-1:0];
        // Carry and half carry are inverted borrows
        flags_o.carry = ~full[DATA_W];
        flags_o.half_carry_flag = ~low[NIB_W];
        flags_o.zero = (full[DATA_W-1:0] == ZERO_BYTE);
        flags_o.twos_complement_range_flag =
            (minuend_i[DATA_W-1] != subtrahend_i[DATA_W-1])
            && (full[DATA_W-1] != minuend_i[DATA_W-1]);
    end
endmodule

// ---- test_subtract_swap_skip_exec.sv ----
// Self-checking bench for the subtract, swap and skip execution block
`timescale 1ns/1ps
module test_subtract_swap_skip_exec;
    import sss_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic exec_valid_i = 1'b0;
    sss_instr_t instr_i = '0;
    logic [1:0] addr = 2'h0;
    logic [7:0] rdata, wdata, wr, exp_wr;
    logic we, skip, dummy, busy;
    sss_flags_t fl, exp_fl;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    sss_exec u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .exec_valid_i(exec_valid_i), .instr_i(instr_i), .mem_rdata_i(rdata),
        .mem_we_o(we), .mem_wdata_o(wdata), .working_register_o(wr),
        .flags_o(fl), .skip_o(skip), .dummy_cycle_o(dummy), .busy_o(busy));
    sss_mem_model u_mem (.clk_i(sys_clk_i), .addr_i(addr), .we_i(we),
        .wdata_i(wdata), .rdata_o(rdata));

    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    function automatic sss_flags_t sub_fl(logic [7:0] a, logic [7:0] b);
        logic [7:0] r;
        r = a - b;
        sub_fl.twos_complement_range_flag = (a[7] != b[7]) && (r[7] != a[7]);
        sub_fl.zero = (r == 8'h00);
        sub_fl.half_carry_flag = (a[3:0] >= b[3:0]);
        sub_fl.carry = (a >= b);
    endfunction
    task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkf(sss_flags_t e, sss_flags_t g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected flags expected %b seen %b", e, g);
        end
    endtask
    task automatic chk1(string n, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic state(logic e_we, logic e_skip);
        chk8("working register", exp_wr, wr);
        chkf(exp_fl, fl);
        chk1("write strobe", e_we, we);
        chk1("skip", e_skip, skip);
        chk1("dummy cycle", e_skip, dummy);
        chk1("busy", e_skip, busy);
    endtask
    // Drive one request at the falling edge, sample after the taking edge
    task automatic run(sss_op_t op, logic [7:0] imm, logic [2:0] bi,
            logic [1:0] a, logic [7:0] m);
        @(negedge sys_clk_i);
        u_mem.mem[a] = m;
        exec_valid_i = 1'b1;
        instr_i = '{op, imm, bi};
        addr = a;
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic idle();
        @(negedge sys_clk_i);
        exec_valid_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_sub_imm();
        logic [7:0] imms [5] = '{8'h01, 8'hff, 8'h7f, 8'h7f, 8'h11};
        foreach (imms[i]) begin
            exp_fl = sub_fl(exp_wr, imms[i]);
            exp_wr = exp_wr - imms[i];
            run(SSS_OP_SUB_IMM, imms[i], 3'h0, 2'h0, 8'h3c);
            state(1'b0, 1'b0);
        end
        // No operation: the constant field must not reach the register
        run(SSS_OP_NONE, 8'hff, 3'h0, 2'h0, 8'h3c);
        state(1'b0, 1'b0);
    endtask
    task automatic t_sub_mem();
        logic [7:0] ms [3] = '{8'h05, 8'h00, 8'hf0};
        foreach (ms[i]) begin
            exp_fl = sub_fl(exp_wr, ms[i]);
            run(SSS_OP_SUB_MEM, 8'h00, 3'h0, 2'h1, ms[i]);
            state(1'b1, 1'b0);
            chk8("write data", exp_wr - ms[i], wdata);
        end
        idle();
        state(1'b0, 1'b0);
        chk8("stored byte", exp_wr - 8'hf0, u_mem.mem[1]);
    endtask
    task automatic t_swap();
        run(SSS_OP_SWAP_MEM, 8'h00, 3'h0, 2'h2, 8'ha5);
        state(1'b1, 1'b0);
        chk8("write data", 8'h5a, wdata);
        // Another byte, so a stray write would show in memory
        exp_wr = 8'hc3;
        run(SSS_OP_SWAP_WR, 8'h00, 3'h0, 2'h3, 8'h3c);
        state(1'b0, 1'b0);
        idle();
        chk8("stored byte", 8'h5a, u_mem.mem[2]);
        chk8("kept byte", 8'h3c, u_mem.mem[3]);
    endtask
    // A taken skip refuses the request that follows it in the dummy cycle
    task automatic skip_case(sss_op_t op, logic [2:0] bi, logic [7:0] m,
            logic taken);
        if (op == SSS_OP_SKIP_NIL_LOAD) begin
            exp_wr = m;
        end
        run(op, 8'h00, bi, 2'h3, m);
        state(1'b0, taken);
        if (taken) begin
            run(SSS_OP_SUB_IMM, 8'h01, 3'h0, 2'h3, m);
            state(1'b0, 1'b0);
        end
    endtask
    task automatic t_skip();
        logic [7:0] m;
        skip_case(SSS_OP_SKIP_NIL, 3'h0, 8'h00, 1'b1);
        skip_case(SSS_OP_SKIP_NIL, 3'h0, 8'h01, 1'b0);
        skip_case(SSS_OP_SKIP_NIL_LOAD, 3'h0, 8'h00, 1'b1);
        skip_case(SSS_OP_SKIP_NIL_LOAD, 3'h0, 8'h80, 1'b0);
        for (int i = 0; i < 8; i++) begin
            m = ~(8'h01 << i);
            skip_case(SSS_OP_SKIP_BIT_CLR, 3'(i), m, 1'b1);
            skip_case(SSS_OP_SKIP_BIT_CLR, 3'(i + 1), m, 1'b0);
        end
        idle();
    endtask
    // Reset in mid-run clears register, flags and write data
    task automatic t_reset();
        @(negedge sys_clk_i);
        sys_rst_i = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        exp_wr = WR_RESET;
        exp_fl = FLAGS_RESET;
        state(1'b0, 1'b0);
        chk8("write data", ZERO_BYTE, wdata);
        // First request lands on the first edge after release
        @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        exec_valid_i = 1'b1;
        instr_i = '{SSS_OP_SUB_IMM, 8'h01, 3'h0};
        exp_fl = sub_fl(exp_wr, 8'h01);
        exp_wr = exp_wr - 8'h01;
        @(posedge sys_clk_i);
        #1;
        state(1'b0, 1'b0);
        idle();
    endtask
    // ----------------------------------------
    // Sequence and verdict
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Ceiling well above the about 53 cycles the scenarios need
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            u_mem.mem[i] = 8'h00;
        end
        exp_wr = WR_RESET;
        exp_fl = FLAGS_RESET;
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        @(posedge sys_clk_i);
        #1;
        state(1'b0, 1'b0);
        t_sub_imm();
        t_sub_mem();
        t_swap();
        t_skip();
        t_reset();
        complete_run();
    end
endmodule
